// ==== shared/mtimer_pkg.sv ====
// Constants and carrier types for the modulo interval timer shared with the PWM block.
// Assumes a single 100 MHz system clock and a synchronous active-low reset.
package mtimer_pkg;
	// ==========================================================
	// Control register layout
	localparam int CTL_SELECT_BIT = 3;
	localparam int CTL_RUN_BIT    = 1;
	localparam int CTL_CLEAR_BIT  = 0;

	// ==========================================================
	// Widths and reset values
	localparam int        LEVEL_W     = 9;
	localparam int        COUNT_W     = 8;
	localparam logic [8:0] LEVEL_RESET = 9'h1ff;
	localparam logic [7:0] COUNT_RESET = 8'h00;

	// ==========================================================
	// Tick rates
	localparam int CLK_HZ       = 100_000_000;
	localparam int FAST_TICK_HZ = 1_125_000;
	localparam int SLOW_TICK_HZ = 112_500;
	// Both periods round down; 100 MHz does not divide evenly
	localparam int FAST_DIV     = CLK_HZ / FAST_TICK_HZ;
	localparam int SLOW_DIV     = CLK_HZ / SLOW_TICK_HZ;

	typedef struct packed {
		logic       write;
		logic [3:0] data;
	} ctl_write_t;

	typedef struct packed {
		logic       write;
		logic [1:0] index;
		logic [8:0] data;
	} level_write_t;

	typedef struct packed {
		logic [2:0] oe;
		logic [2:0] level;
	} pin_drive_t;
endpackage

// ==== rtl/tick_divider.sv ====
// Free-running prescaler that makes the timer's basic clock tick.
// Assumes one system clock; the phase is never realigned on a counter clear.
`timescale 1ns/10ps
module tick_divider #(
	parameter int FAST_DIV = mtimer_pkg::FAST_DIV,
	parameter int SLOW_DIV = mtimer_pkg::SLOW_DIV
) (
	input  wire logic mclk_in,
	input  wire logic rstn_in,
	input  wire logic slow_sel_in,
	output logic      tick_out
);
	localparam int W = $clog2(SLOW_DIV + 1);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         tick_r;
	logic         tick_nxt;
	logic [W-1:0] limit;

	// ==========================================================
	// Counting
	always_comb begin
		limit = slow_sel_in ? W'(SLOW_DIV - 1) : W'(FAST_DIV - 1);
		// A source change lets the count run on to the new limit, or wrap at once if already at or past it
		if (cnt_r >= limit) begin
			cnt_nxt  = '0;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt  = cnt_r + W'(1);
			tick_nxt = 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_out = tick_r;
endmodule

// ==== rtl/modulo_interval_timer.sv ====
// Modulo interval timer sharing its limit register and pins with a three-channel PWM block.
// Assumes the core writes the control nibble and level registers as one-cycle strobes.
//
// Notes on behaviour
// RULE1 - Basic clock reaches the counter only while the run flag is set.
// RULE2 - Run and clear act only when timer function is selected.
// RULE3 - Interrupt request when counter equals the match limit value.
// RULE4 - Writing the clear flag resets the counter to zero.
// RULE5 - Match limit and PWM level register two are one storage location.
// RULE6 - Level registers one and zero stay plain 9-bit latches in timer mode.
// RULE7 - Start may lag one tick, stop may lose one tick.
// RULE8 - After clear the next count may lag up to one tick.
// RULE9 - Changing tick source may delay the next count one new period.
// RULE10 - Timer mode forces all three PWM pins to port output mode.
// RULE11 - Power-on and watchdog reset: pins port output low, levels 1FFH.
// RULE12 - Clock stop: pins port mode, latches kept, levels 1FFH.
// RULE13 - Chip enable reset keeps state; in timer use masks interrupts.
// RULE14 - Halt keeps PWM output and timer counting unchanged.
// RULE15 - Tick source select picks 1.125 MHz or 112.5 kHz.
// RULE16 - Timer mode uses the shared counter as eight bits.
// RULE17 - Control bit 3 select, bit 1 run, bit 0 clear.
// RULE18 - On match the counter returns to zero and keeps counting.
// RULE19 - With run clear the counter holds and raises no requests.
`timescale 1ns/10ps
module modulo_interval_timer (
	input  wire logic                      mclk_in,
	input  wire logic                      rstn_in,
	input  wire logic                      watchdog_stack_reset_in,
	input  wire logic                      clock_stop_in,
	input  wire logic                      chip_enable_reset_in,
	input  wire logic                      halt_in,
	input  wire mtimer_pkg::ctl_write_t    ctl_wr_in,
	input  wire mtimer_pkg::level_write_t  level_wr_in,
	input  wire logic                      tick_source_select_in,
	input  wire logic [2:0]                port_latch_in,
	input  wire logic [2:0]                pwm_wave_in,
	output logic [3:0]                     ctl_rd_out,
	output logic [7:0]                     count_out,
	output logic [8:0]                     pwm_level_register_zero_out,
	output logic [8:0]                     pwm_level_register_one_out,
	output logic [8:0]                     match_limit_register_out,
	output logic                           timer_irq_out,
	output logic                           interrupts_masked_state_out,
	output logic                           port_mode_out,
	output mtimer_pkg::pin_drive_t         pins_out
);
	logic                  tick;
	logic                  select_r;
	logic                  select_nxt;
	logic                  run_r;
	logic                  run_nxt;
	logic [7:0]            count_r;
	logic [7:0]            count_nxt;
	logic                  irq_r;
	logic                  irq_nxt;
	logic                  mask_r;
	logic                  mask_nxt;
	logic [2:0][8:0]       level_r;
	logic [2:0][8:0]       level_nxt;
	mtimer_pkg::pin_drive_t pins_r;
	mtimer_pkg::pin_drive_t pins_nxt;
	logic                  port_r;
	logic                  port_nxt;
	logic                  hard_reset;
	logic                  clear_req;

	// ==========================================================
	// Basic clock
	tick_divider u_div (
		.mclk_in     (mclk_in),
		.rstn_in     (rstn_in),
		.slow_sel_in (tick_source_select_in), // [RULE15] [RULE9]
		.tick_out    (tick)
	);

	assign hard_reset = watchdog_stack_reset_in;

	// ==========================================================
	// Control decode
	// A control write either claims the shared counter for the timer or hands it to PWM
	function automatic logic names_timer(input mtimer_pkg::ctl_write_t w);
		names_timer = w.write & w.data[mtimer_pkg::CTL_SELECT_BIT];
	endfunction

	function automatic logic names_pwm(input mtimer_pkg::ctl_write_t w);
		names_pwm = w.write & ~w.data[mtimer_pkg::CTL_SELECT_BIT];
	endfunction

	// ==========================================================
	// Control flags
	always_comb begin
		select_nxt = select_r;
		run_nxt    = run_r;
		clear_req  = 1'b0;
		if (hard_reset) begin
			select_nxt = 1'b0;
			run_nxt    = 1'b0;
		end else if (ctl_wr_in.write) begin
			select_nxt = names_timer(ctl_wr_in);                     // [RULE17]
			run_nxt    = ctl_wr_in.data[mtimer_pkg::CTL_RUN_BIT];    // [RULE17]
			// Clear is a write-only action; it never stores
			clear_req  = ctl_wr_in.data[mtimer_pkg::CTL_CLEAR_BIT] &
				names_timer(ctl_wr_in);                              // [RULE2] [RULE4]
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			select_r <= 1'b0;
			run_r    <= 1'b0;
		end else begin
			select_r <= select_nxt;
			run_r    <= run_nxt;
		end
	end

	// ==========================================================
	// Counter and match
	always_comb begin
		count_nxt = count_r;
		irq_nxt   = 1'b0;
		if (hard_reset) begin
			count_nxt = mtimer_pkg::COUNT_RESET;
		end else if (clear_req) begin
			// Prescaler is left alone, so the first tick may come early or late
			count_nxt = mtimer_pkg::COUNT_RESET; // [RULE4] [RULE8]
		end else if (select_r && run_r && tick) begin // [RULE1] [RULE2] [RULE7] [RULE19]
			// Halt and chip enable reset do not stop counting
			if (count_r == level_r[2][7:0]) begin // [RULE3] [RULE16] [RULE14]
				count_nxt = mtimer_pkg::COUNT_RESET; // [RULE18]
				irq_nxt   = 1'b1;                     // [RULE3]
			end else begin
				count_nxt = count_r + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			count_r <= mtimer_pkg::COUNT_RESET;
			irq_r   <= 1'b0;
		end else begin
			count_r <= count_nxt;
			irq_r   <= irq_nxt;
		end
	end

	// ==========================================================
	// Level registers, shared limit
	always_comb begin
		level_nxt = level_r;
		if (hard_reset || clock_stop_in) begin
			for (int i = 0; i < 3; i++) begin
				level_nxt[i] = mtimer_pkg::LEVEL_RESET; // [RULE11] [RULE12]
			end
		end else if (level_wr_in.write && level_wr_in.index != 2'd3) begin
			// Index two is the match limit as well as PWM channel two
			level_nxt[level_wr_in.index] = level_wr_in.data; // [RULE5] [RULE6]
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			level_r <= {3{mtimer_pkg::LEVEL_RESET}}; // [RULE11]
		end else begin
			level_r <= level_nxt;
		end
	end

	// ==========================================================
	// Interrupt mask
	always_comb begin
		mask_nxt = mask_r;
		if (hard_reset) begin
			mask_nxt = 1'b0;
		end else if (chip_enable_reset_in && select_r) begin
			mask_nxt = 1'b1; // [RULE13]
		end else if (names_pwm(ctl_wr_in)) begin
			// Handing the counter back to PWM is the only software release of the mask
			mask_nxt = 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			mask_r <= 1'b0;
		end else begin
			mask_r <= mask_nxt;
		end
	end

	// ==========================================================
	// Pins
	always_comb begin
		port_nxt       = port_r;
		pins_nxt.oe    = 3'b111;
		pins_nxt.level = pins_r.level;
		if (hard_reset) begin
			port_nxt       = 1'b1;
			pins_nxt.level = 3'b000; // [RULE11]
		end else if (clock_stop_in) begin
			port_nxt       = 1'b1;
			pins_nxt.level = port_latch_in; // [RULE12]
		end else if (select_r) begin
			port_nxt       = 1'b1;
			pins_nxt.level = port_latch_in; // [RULE10]
		end else begin
			// Chip enable reset and halt leave the PWM waveform running
			port_nxt       = 1'b0;
			pins_nxt.level = pwm_wave_in; // [RULE14]
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			pins_r <= '{oe: 3'b111, level: 3'b000}; // [RULE11]
			port_r <= 1'b1;
		end else begin
			pins_r <= pins_nxt;
			port_r <= port_nxt;
		end
	end

	assign ctl_rd_out                  = {select_r, 1'b0, run_r, 1'b0};
	assign count_out                   = count_r;
	assign pwm_level_register_zero_out = level_r[0];
	assign pwm_level_register_one_out  = level_r[1];
	assign match_limit_register_out    = level_r[2];
	assign timer_irq_out               = irq_r;
	assign interrupts_masked_state_out = mask_r;
	assign port_mode_out               = port_r;
	assign pins_out                    = pins_r;
endmodule

// ==== tb/mtimer_chk.sv ====
// Port checker for the modulo interval timer.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module mtimer_chk (
	input wire logic                     mclk_in,
	input wire logic                     rstn_in,
	input wire logic                     watchdog_stack_reset_in,
	input wire logic                     clock_stop_in,
	input wire logic                     chip_enable_reset_in,
	input wire mtimer_pkg::ctl_write_t   ctl_wr_in,
	input wire mtimer_pkg::level_write_t level_wr_in,
	input wire logic [3:0]               ctl_rd_out,
	input wire logic [7:0]               count_out,
	input wire logic [8:0]               pwm_level_register_one_out,
	input wire logic [8:0]               match_limit_register_out,
	input wire logic                     timer_irq_out,
	input wire logic                     interrupts_masked_state_out,
	input wire logic                     port_mode_out,
	input wire mtimer_pkg::pin_drive_t   pins_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	logic quiet;
	logic no_rst;
	assign no_rst = !watchdog_stack_reset_in && !clock_stop_in;
	assign quiet = !ctl_wr_in.write && no_rst;
	// ==========================================================
	// Counting
	a_irq_pulse: assert property (timer_irq_out |=> !timer_irq_out)
		else $error("irq longer than one cycle");
	a_irq_wrap: assert property (timer_irq_out |-> count_out == 8'h00
		&& $past(count_out) == $past(match_limit_register_out[7:0])) else $error("bad wrap");
	a_stop_hold: assert property (!ctl_rd_out[1] && quiet
		|=> $stable(count_out) && !timer_irq_out) else $error("count moved while stopped");
	a_clear_zero: assert property (ctl_wr_in.write && ctl_wr_in.data[3]
		&& ctl_wr_in.data[0] |=> count_out == 8'h00) else $error("clear missed");
	a_clear_refuse: assert property (ctl_wr_in.write && !ctl_wr_in.data[3]
		&& !(ctl_rd_out[3] && ctl_rd_out[1]) && no_rst
		|=> $stable(count_out)) else $error("clear not refused");
	// ==========================================================
	// Pins, levels and resets
	a_timer_port: assert property (ctl_rd_out[3] && $past(ctl_rd_out[3]) |-> port_mode_out)
		else $error("timer mode without port mode");
	a_wd_reset: assert property (watchdog_stack_reset_in |=> port_mode_out
		&& pins_out.level == 3'h0 && match_limit_register_out == 9'h1ff) else $error("wd reset");
	a_stop_levels: assert property (clock_stop_in |=> port_mode_out
		&& pwm_level_register_one_out == 9'h1ff) else $error("clock stop levels");
	a_limit_write: assert property (level_wr_in.write && level_wr_in.index == 2'h2
		&& no_rst |=> match_limit_register_out == $past(level_wr_in.data)) else $error("limit");
	a_ce_mask: assert property (chip_enable_reset_in && ctl_rd_out[3] && quiet
		|=> interrupts_masked_state_out) else $error("mask not set");
	cover property (timer_irq_out);
	cover property (chip_enable_reset_in && ctl_rd_out[3]);
	cover property (clock_stop_in);
endmodule
bind modulo_interval_timer mtimer_chk mtimer_chk_inst (.mclk_in(mclk_in), .rstn_in(rstn_in),
	.watchdog_stack_reset_in(watchdog_stack_reset_in), .clock_stop_in(clock_stop_in),
	.chip_enable_reset_in(chip_enable_reset_in), .ctl_wr_in(ctl_wr_in),
	.level_wr_in(level_wr_in), .ctl_rd_out(ctl_rd_out), .count_out(count_out),
	.pwm_level_register_one_out(pwm_level_register_one_out), .pins_out(pins_out),
	.match_limit_register_out(match_limit_register_out), .timer_irq_out(timer_irq_out),
	.interrupts_masked_state_out(interrupts_masked_state_out), .port_mode_out(port_mode_out));

// ==== tb/tb.sv ====
// Self-checking bench for the modulo interval timer.
// Assumes the checker is bound separately; inputs move 1 ns after each edge.
`timescale 1ns/10ps
module tb;
	logic                     mclk_in, rstn_in, wd, stp, ce, halt, src, irq, mask, pm;
	logic [2:0]               latch, wave;
	logic [3:0]               ctl;
	logic [7:0]               cnt;
	logic [8:0]               l0, l1, lm, v;
	logic [8:0]               e [3];
	mtimer_pkg::ctl_write_t   cw;
	mtimer_pkg::level_write_t lw;
	mtimer_pkg::pin_drive_t   pins;
	int                       num_errors, compares, n, lim;
	modulo_interval_timer modulo_interval_timer_inst (.mclk_in(mclk_in), .rstn_in(rstn_in),
		.watchdog_stack_reset_in(wd), .clock_stop_in(stp), .chip_enable_reset_in(ce),
		.halt_in(halt), .ctl_wr_in(cw), .level_wr_in(lw), .tick_source_select_in(src),
		.port_latch_in(latch), .pwm_wave_in(wave), .ctl_rd_out(ctl), .count_out(cnt),
		.pwm_level_register_zero_out(l0), .pwm_level_register_one_out(l1),
		.match_limit_register_out(lm), .timer_irq_out(irq), .interrupts_masked_state_out(mask),
		.port_mode_out(pm), .pins_out(pins));
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	task automatic step(input int k);
		repeat (k) @(posedge mclk_in);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Each write strobe is followed by an idle edge so no signal is set twice in one step
	task automatic ctl_wr(input logic [3:0] d);
		cw = '{1'b1, d};
		step(1);
		cw = '0;
		step(1);
	endtask
	task automatic lv_wr(input logic [1:0] i, input logic [8:0] d);
		lw = '{1'b1, i, d};
		step(1);
		lw = '0;
		step(1);
	endtask
	task automatic wait_irq(output int k);
		k = 0;
		do begin
			step(1);
			k++;
		end while (irq !== 1'b1 && k < 3000);
		if (k >= 3000) begin
			num_errors++;
			results();
		end
	endtask
	initial begin
		{rstn_in, wd, stp, ce, halt, src} = 6'h00;
		cw = '0;
		lw = '0;
		num_errors = 0;
		compares = 0;
		void'($urandom(75142));
		latch = 3'($urandom);
		wave = 3'($urandom);
		e = '{9'h1ff, 9'h1ff, 9'h1ff};
		step(5);
		chk("pins", pins, 16'h0038);
		chk("limit", lm, 16'h01ff);
		rstn_in = 1'b1;
		ctl_wr(4'h8);
		for (int i = 0; i < 12; i++) begin
			v = 9'($urandom);
			lv_wr(2'(i), v);
			if (i % 4 < 3)
				e[i % 4] = v;
			chk("lvl0", l0, e[0]);
			chk("lvl1", l1, e[1]);
			chk("lvl2", lm, e[2]);
		end
		lim = 2 + $urandom % 5;
		lv_wr(2'h2, 9'(lim));
		ctl_wr(4'hb);
		chk("ctl", ctl, 16'h000a);
		chk("port", pm, 16'h0001);
		wait_irq(n);
		chk("wrap", cnt, 16'h0000);
		halt = 1'b1;
		wait_irq(n);
		chk("period", 16'(n), 16'((lim + 1) * mtimer_pkg::FAST_DIV));
		halt = 1'b0;
		ce = 1'b1;
		step(1);
		ce = 1'b0;
		chk("mask", mask, 16'h0001);
		wait_irq(n);
		// The chip enable pulse used up one edge of this interval
		chk("ce period", 16'(n + 1), 16'((lim + 1) * mtimer_pkg::FAST_DIV));
		step(200);
		ctl_wr(4'h8);
		v = 9'(cnt);
		step(300);
		chk("held", cnt, v);
		ctl_wr(4'h1);
		chk("refused", cnt, v);
		ctl_wr(4'h9);
		chk("cleared", cnt, 16'h0000);
		stp = 1'b1;
		step(1);
		stp = 1'b0;
		chk("stop lvl", lm, 16'h01ff);
		chk("stop pins", pins.level, latch);
		// Move a level off its reset value so the watchdog reload is visible
		lv_wr(2'h0, 9'h0a5);
		wd = 1'b1;
		step(1);
		wd = 1'b0;
		chk("wd pins", pins, 16'h0038);
		chk("wd lvl0", l0, 16'h01ff);
		ce = 1'b1;
		step(1);
		ce = 1'b0;
		chk("ce idle mask", mask, 16'h0000);
		chk("pwm pins", pins.level, wave);
		chk("pwm mode", pm, 16'h0000);
		ctl_wr(4'h3);
		step(200);
		chk("no select", cnt, 16'h0000);
		lv_wr(2'h2, 9'h001);
		src = 1'b1;
		ctl_wr(4'hb);
		wait_irq(n);
		wait_irq(n);
		chk("slow period", 16'(n), 16'(2 * mtimer_pkg::SLOW_DIV));
		results();
	end
endmodule
